// File: rtl/wdt_core.sv
// Watchdog timer with sleep wake, control registers and wake logic.
// Assumes the core drives clear and sleep as one-cycle pulses and the
// oscillators arrive as free-running pins from another domain.
//
// The strobed register port was left to the implementer.
`timescale 1ns/1ps
module wdt_core
  import wdt_pkg::*;
(
  input  wire logic              clock_i,
  input  wire logic              rst_n_i,
  // Register port.
  input  wire logic [ADDR_W-1:0] addr_i,
  input  wire logic [DATA_W-1:0] wdata_i,
  input  wire logic              wr_i,
  input  wire logic              rd_i,
  output logic [DATA_W-1:0]      rdata_o,
  // Configuration and core side.
  input  wire logic [1:0]        wdt_mode_select_i,
  input  wire logic              watchdog_clear_instruction_i,
  input  wire logic              sleep_instruction_i,
  input  wire logic              global_interrupt_enable_i,
  input  wire logic              interrupt_pending_i,
  // Oscillator pins.
  input  wire logic              secondary_oscillator_i,
  input  wire logic              low_freq_internal_osc_i,
  // Results.
  output logic                   wdt_reset_o,
  output logic                   wake_o,
  output logic                   isr_call_o,
  output logic                   asleep_o,
  output logic                   time_out_flag_n_o,
  output logic                   powerdown_flag_n_o,
  output logic                   watchdog_reset_flag_n_o,
  output logic                   irq_o
);

  // -----------------------------------------------------------------
  // Declarations
  // -----------------------------------------------------------------
  logic             clk_sel_q;
  logic [PS_W-1:0]  wdt_prescale_select_q;
  logic             software_wdt_enable_q;
  wdt_power_e       power_q;
  logic             to_n_q;
  logic             pd_n_q;
  logic             watchdog_reset_flag_n_n_q;
  logic [IRQ_W-1:0] irq_stat_q;
  logic [IRQ_W-1:0] irq_mask_q;
  logic [DATA_W-1:0] rdata_q;
  logic             wdt_reset_q;
  logic             wake_q;
  logic             isr_call_q;

  logic [1:0]       secondary_oscillator_sync_q;
  logic [1:0]       lfo_sync_q;
  logic             secondary_oscillator_prev_q;
  logic             lfo_prev_q;
  logic             tick;

  logic             wr_control;
  logic             wr_flags;
  logic             wr_irq_stat;
  logic             wr_irq_mask;
  logic             asleep;
  logic             active;
  logic             sleep_nop;
  logic             sleep_enter;
  logic             clear_valid;
  logic             expire;
  logic             expire_awake;
  logic             expire_asleep;
  logic             int_wake;
  logic             wake_now;
  logic             restart;
  logic [IRQ_W-1:0] irq_events;

  // -----------------------------------------------------------------
  // Register decode
  // -----------------------------------------------------------------
  assign wr_control  = wr_i && (addr_i == ADDR_CONTROL);
  assign wr_flags    = wr_i && (addr_i == ADDR_FLAGS);
  assign wr_irq_stat = wr_i && (addr_i == ADDR_IRQ_STAT);
  assign wr_irq_mask = wr_i && (addr_i == ADDR_IRQ_MASK);

  // -----------------------------------------------------------------
  // Oscillator synchronisers and tick selection
  // -----------------------------------------------------------------
  // Both oscillators are far slower than the system clock, so a rising
  // edge seen after two flops is a clean one-cycle tick.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      secondary_oscillator_sync_q <= 2'h0;
      lfo_sync_q  <= 2'h0;
      secondary_oscillator_prev_q <= 1'b0;
      lfo_prev_q  <= 1'b0;
    end else begin
      secondary_oscillator_sync_q <= {secondary_oscillator_sync_q[0], secondary_oscillator_i};
      lfo_sync_q  <= {lfo_sync_q[0], low_freq_internal_osc_i};
      secondary_oscillator_prev_q <= secondary_oscillator_sync_q[1];
      lfo_prev_q  <= lfo_sync_q[1];
    end
  end

  assign tick = clk_sel_q ? (secondary_oscillator_sync_q[1] && !secondary_oscillator_prev_q)
                          : (lfo_sync_q[1] && !lfo_prev_q);

  // -----------------------------------------------------------------
  // Operating mode
  // -----------------------------------------------------------------
  assign asleep = (power_q == WDT_ASLEEP);

  always_comb begin
    case (wdt_mode_select_i)
      MODE_ALWAYS: active = 1'b1;
      MODE_AWAKE:  active = !asleep;
      MODE_SOFT:   active = software_wdt_enable_q;
      MODE_OFF:    active = 1'b0;
      default:     active = 1'b0;
    endcase
  end

  // -----------------------------------------------------------------
  // Sleep, wake and clear events
  // -----------------------------------------------------------------
  // A pending enabled interrupt at the sleep instruction turns it into
  // a no-op; the global enable plays no part in either decision.
  assign sleep_nop   = sleep_instruction_i && !asleep
                       && interrupt_pending_i;
  assign sleep_enter = sleep_instruction_i && !asleep
                       && !interrupt_pending_i;
  assign clear_valid = watchdog_clear_instruction_i && !asleep;
  assign expire_awake  = expire && !asleep;
  assign expire_asleep = expire && asleep;
  assign int_wake    = asleep && interrupt_pending_i;
  assign wake_now    = expire_asleep || int_wake;

  // Sleep entry restarts the count before it runs on in sleep, so the
  // full period is available after entry.
  assign restart = wr_control || clear_valid || sleep_enter
                   || wake_now || expire_awake;

  wdt_prescaler #(
    .CW        (CNT_W)
  ) u_prescaler (
    .clock_i   (clock_i),
    .rst_n_i   (rst_n_i),
    .restart_i (restart),
    .run_i     (active),
    .tick_i    (tick),
    .code_i    (wdt_prescale_select_q),
    .expire_o  (expire),
    .count_o   ()
  );

  // -----------------------------------------------------------------
  // Control register
  // -----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      clk_sel_q             <= CS_RESET;
      wdt_prescale_select_q <= PS_RESET;
      software_wdt_enable_q <= SEN_RESET;
    end else if (wr_control) begin
      clk_sel_q             <= wdata_i[CTL_CS_BIT];
      wdt_prescale_select_q <= wdata_i[CTL_PS_MSB:CTL_PS_LSB];
      software_wdt_enable_q <= wdata_i[CTL_SEN_BIT];
    end
  end

  // -----------------------------------------------------------------
  // Power state
  // -----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      power_q <= WDT_RUN;
    end else begin
      case (power_q)
        WDT_RUN: begin
          if (sleep_enter) begin
            power_q <= WDT_ASLEEP;
          end
        end
        WDT_ASLEEP: begin
          if (wake_now) begin
            power_q <= WDT_RUN;
          end
        end
        default: power_q <= WDT_RUN;
      endcase
    end
  end

  // -----------------------------------------------------------------
  // Status flags, active low
  // -----------------------------------------------------------------
  // Hardware events win over a firmware write in the same cycle. A
  // firmware write of one restores a flag; a zero leaves it alone.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      to_n_q <= FLAGS_RESET[FLG_TO_BIT];
    end else if (expire_asleep || expire_awake) begin
      to_n_q <= 1'b0;
    end else if (sleep_enter || clear_valid) begin
      to_n_q <= 1'b1;
    end else if (wr_flags && wdata_i[FLG_TO_BIT]) begin
      to_n_q <= 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      pd_n_q <= FLAGS_RESET[FLG_PD_BIT];
    end else if (sleep_enter || expire_asleep) begin
      pd_n_q <= 1'b0;
    end else if (clear_valid) begin
      pd_n_q <= 1'b1;
    end else if (wr_flags && wdata_i[FLG_PD_BIT]) begin
      pd_n_q <= 1'b1;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      watchdog_reset_flag_n_n_q <= FLAGS_RESET[FLG_WATCHDOG_RESET_FLAG_N_BIT];
    end else if (expire_asleep || expire_awake) begin
      watchdog_reset_flag_n_n_q <= 1'b0;
    end else if (wr_flags && wdata_i[FLG_WATCHDOG_RESET_FLAG_N_BIT]) begin
      watchdog_reset_flag_n_n_q <= 1'b1;
    end
  end

  // -----------------------------------------------------------------
  // Reset and wake pulses
  // -----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      wdt_reset_q <= 1'b0;
      wake_q      <= 1'b0;
      isr_call_q  <= 1'b0;
    end else begin
      wdt_reset_q <= expire_awake;
      wake_q      <= wake_now;
      isr_call_q  <= int_wake && global_interrupt_enable_i;
    end
  end

  // -----------------------------------------------------------------
  // Interrupt status and mask
  // -----------------------------------------------------------------
  always_comb begin
    irq_events                  = '0;
    irq_events[IRQ_RESET_BIT]   = expire_awake;
    irq_events[IRQ_TOWAKE_BIT]  = expire_asleep;
    irq_events[IRQ_INTWAKE_BIT] = int_wake;
  end

  // Set wins over a write-one clear in the same cycle.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      irq_stat_q <= IRQ_RESET_VAL;
    end else if (wr_irq_stat) begin
      irq_stat_q <= (irq_stat_q & ~wdata_i[IRQ_W-1:0]) | irq_events;
    end else begin
      irq_stat_q <= irq_stat_q | irq_events;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      irq_mask_q <= IRQ_RESET_VAL;
    end else if (wr_irq_mask) begin
      irq_mask_q <= wdata_i[IRQ_W-1:0];
    end
  end

  // -----------------------------------------------------------------
  // Read data
  // -----------------------------------------------------------------
  always_ff @(posedge clock_i) begin
    if (!rst_n_i) begin
      rdata_q <= '0;
    end else if (rd_i) begin
      case (addr_i)
        ADDR_CONTROL: begin
          rdata_q                          <= '0;
          rdata_q[CTL_CS_BIT]              <= clk_sel_q;
          rdata_q[CTL_PS_MSB:CTL_PS_LSB]   <= wdt_prescale_select_q;
          rdata_q[CTL_SEN_BIT]             <= software_wdt_enable_q;
        end
        ADDR_FLAGS: begin
          rdata_q                          <= '0;
          rdata_q[FLG_TO_BIT]              <= to_n_q;
          rdata_q[FLG_PD_BIT]              <= pd_n_q;
          rdata_q[FLG_WATCHDOG_RESET_FLAG_N_BIT]            <= watchdog_reset_flag_n_n_q;
        end
        ADDR_IRQ_STAT: rdata_q <= {{(DATA_W-IRQ_W){1'b0}}, irq_stat_q};
        ADDR_IRQ_MASK: rdata_q <= {{(DATA_W-IRQ_W){1'b0}}, irq_mask_q};
        default:       rdata_q <= '0;
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  // -----------------------------------------------------------------
  // Outputs
  // -----------------------------------------------------------------
  assign rdata_o                 = rdata_q;
  assign wdt_reset_o             = wdt_reset_q;
  assign wake_o                  = wake_q;
  assign isr_call_o              = isr_call_q;
  assign asleep_o                = asleep;
  assign time_out_flag_n_o       = to_n_q;
  assign powerdown_flag_n_o      = pd_n_q;
  assign watchdog_reset_flag_n_o = watchdog_reset_flag_n_n_q;
  assign irq_o                   = |(irq_stat_q & irq_mask_q);

endmodule : wdt_core

// File: rtl/wdt_pkg.sv
// Constants, register map and types of the watchdog timer with sleep wake.
// Assumes one 100 MHz system clock and a plain strobe register port.
package wdt_pkg;

  localparam int          ADDR_W        = 12;
  localparam int          DATA_W        = 8;
  localparam int          PS_W          = 5;
  localparam int          CNT_W         = 23;

  // Register byte addresses.
  localparam logic [11:0] ADDR_CONTROL  = 12'h18C;
  localparam logic [11:0] ADDR_FLAGS    = 12'h190;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h194;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h198;

  // Control register fields.
  localparam int          CTL_CS_BIT    = 7;
  localparam int          CTL_PS_LSB    = 1;
  localparam int          CTL_PS_MSB    = 5;
  localparam int          CTL_SEN_BIT   = 0;

  // Flags register fields, all active low.
  localparam int          FLG_TO_BIT    = 0;
  localparam int          FLG_PD_BIT    = 1;
  localparam int          FLG_WATCHDOG_RESET_FLAG_N_BIT  = 2;
  localparam logic [2:0]  FLAGS_RESET   = 3'h7;

  // Interrupt status fields.
  localparam int          IRQ_RESET_BIT = 0;
  localparam int          IRQ_TOWAKE_BIT = 1;
  localparam int          IRQ_INTWAKE_BIT = 2;
  localparam int          IRQ_W         = 3;

  // Reset values and the largest prescale code.
  localparam logic        CS_RESET      = 1'h0;
  localparam logic [4:0]  PS_RESET      = 5'h0B;
  localparam logic        SEN_RESET     = 1'h0;
  localparam logic [4:0]  PS_MAX_CODE   = 5'h12;
  localparam logic [2:0]  IRQ_RESET_VAL = 3'h0;

  // Mode select encodings.
  localparam logic [1:0]  MODE_OFF      = 2'h0;
  localparam logic [1:0]  MODE_SOFT     = 2'h1;
  localparam logic [1:0]  MODE_AWAKE    = 2'h2;
  localparam logic [1:0]  MODE_ALWAYS   = 2'h3;

  typedef enum logic {
    WDT_RUN,
    WDT_ASLEEP
  } wdt_power_e;

  // Last count of the selected division, ratio minus one.
  function automatic logic [CNT_W-1:0] wdt_last_count(
    input logic [PS_W-1:0] code
  );
    logic [PS_W-1:0] eff;
    logic [CNT_W:0]  ratio;
    eff   = (code > PS_MAX_CODE) ? 5'h00 : code;
    ratio = (CNT_W+1)'(32) << eff;
    return CNT_W'(ratio - (CNT_W+1)'(1));
  endfunction : wdt_last_count

endpackage : wdt_pkg

// File: rtl/wdt_prescaler.sv
// Watchdog divider: counts ticks of the selected slow clock.
// Assumes ticks are one-cycle pulses on the system clock.
`timescale 1ns/1ps
module wdt_prescaler
  import wdt_pkg::*;
#(
  parameter int CW = CNT_W
) (
  input  wire logic            clock_i,
  input  wire logic            rst_n_i,
  input  wire logic            restart_i,
  input  wire logic            run_i,
  input  wire logic            tick_i,
  input  wire logic [PS_W-1:0] code_i,
  output logic                 expire_o,
  output logic [CW-1:0]        count_o
);

  logic [CW-1:0] count_q;
  logic          expire_q;
  logic [CW-1:0] last;

  assign last = CW'(wdt_last_count(code_i));

  // -----------------------------------------------------------------
  // Counter
  // -----------------------------------------------------------------
  // A restart takes priority over a tick in the same cycle, so a clear
  // issued with the final tick stops the expiry; one issued once expire_o is high does not.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || restart_i) begin
      count_q <= '0;
    end else if (run_i && tick_i) begin
      if (count_q >= last) begin
        count_q <= '0;
      end else begin
        count_q <= count_q + CW'(1);
      end
    end
  end

  always_ff @(posedge clock_i) begin
    if (!rst_n_i || restart_i) begin
      expire_q <= 1'b0;
    end else begin
      expire_q <= run_i && tick_i && (count_q >= last);
    end
  end

  assign expire_o = expire_q;
  assign count_o  = count_q;

endmodule : wdt_prescaler

// File: sim/wdt_checker.sv
// Assertions on the watchdog core ports.
// Assumes it is bound into wdt_core with its ports joined by name.
`timescale 1ns/1ps
module wdt_checker
  import wdt_pkg::*;
(
  input wire logic              clock_i,
  input wire logic              rst_n_i,
  input wire logic [ADDR_W-1:0] addr_i,
  input wire logic              rd_i,
  input wire logic [DATA_W-1:0] rdata_o,
  input wire logic [1:0]        wdt_mode_select_i,
  input wire logic              watchdog_clear_instruction_i,
  input wire logic              sleep_instruction_i,
  input wire logic              global_interrupt_enable_i,
  input wire logic              interrupt_pending_i,
  input wire logic              wdt_reset_o,
  input wire logic              wake_o,
  input wire logic              isr_call_o,
  input wire logic              asleep_o,
  input wire logic              time_out_flag_n_o,
  input wire logic              powerdown_flag_n_o,
  input wire logic              watchdog_reset_flag_n_o
);
  // ------------------------------------------------------------
  // Properties
  // ------------------------------------------------------------
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);

  AST_SLEEP_NOP: assert property (
    sleep_instruction_i && interrupt_pending_i && !asleep_o
    && !watchdog_clear_instruction_i |=> !asleep_o
    && powerdown_flag_n_o == $past(powerdown_flag_n_o))
    else $error("sleep with pending interrupt not ignored");
  AST_SLEEP_IN: assert property (
    sleep_instruction_i && !interrupt_pending_i && !asleep_o |=>
    asleep_o && !powerdown_flag_n_o && time_out_flag_n_o)
    else $error("sleep entry wrong");
  AST_INT_WAKE: assert property (
    asleep_o && interrupt_pending_i |=> wake_o && !asleep_o
    && isr_call_o == $past(global_interrupt_enable_i))
    else $error("interrupt wake wrong");
  AST_TO_WAKE: assert property (
    wake_o && !$past(interrupt_pending_i) |-> !wdt_reset_o
    && !time_out_flag_n_o && !powerdown_flag_n_o
    && !watchdog_reset_flag_n_o)
    else $error("expiry wake wrong");
  AST_MODE_OFF: assert property (
    wdt_mode_select_i == MODE_OFF && $past(wdt_mode_select_i) == MODE_OFF
    |-> !wdt_reset_o)
    else $error("reset while disabled");
  AST_SLEEP_OFF: assert property (
    asleep_o && !interrupt_pending_i && wdt_mode_select_i == MODE_AWAKE
    && $past(wdt_mode_select_i) == MODE_AWAKE |=> !wake_o)
    else $error("watchdog ran asleep in mode 10");
  AST_CLEAR: assert property (
    watchdog_clear_instruction_i && !asleep_o |=>
    time_out_flag_n_o && powerdown_flag_n_o)
    else $error("clear left flags low");
  AST_RST_FLAGS: assert property (
    wdt_reset_o |-> !time_out_flag_n_o && !watchdog_reset_flag_n_o
    && !asleep_o)
    else $error("reset pulse without flags");
  AST_CTL_BIT6: assert property (
    rd_i && addr_i == ADDR_CONTROL |=> rdata_o[6] == 1'b0)
    else $error("control bit 6 read one");

  COV_NOP: cover property (sleep_instruction_i && interrupt_pending_i);
  COV_TO_WAKE: cover property (wake_o && !time_out_flag_n_o);
  COV_RESET: cover property (wdt_reset_o);
endmodule : wdt_checker

// File: sim/wdt_core_model.sv
// Processor core stand-in: clear and sleep pulses, slow clocks.
// Assumes requests from the bench arrive one cycle before the pulse.
`timescale 1ns/1ps
module wdt_core_model (
  input  wire logic clock_i,
  input  wire logic rst_n_i,
  input  wire logic auto_clear_i,
  input  wire logic sleep_req_i,
  output logic      clear_o,
  output logic      sleep_o,
  output logic      secondary_oscillator_o,
  output logic      lfosc_o
);
  logic [6:0] cnt_q;
  // The oscillators run free of reset, as real ones would. A plain always
  // is used because the divider also carries a declaration initialiser.
  logic [3:0] div_q = 4'h0;

  always @(posedge clock_i) begin
    div_q <= div_q + 4'h1;
  end

  assign lfosc_o = div_q[2];
  assign secondary_oscillator_o  = div_q[3];

  // Firmware clears every 100 cycles, well inside a 256 cycle time-out.
  always_ff @(posedge clock_i) begin
    if (!rst_n_i || !auto_clear_i) begin
      cnt_q   <= 7'h00;
      clear_o <= 1'b0;
    end else begin
      cnt_q   <= (cnt_q == 7'h63) ? 7'h00 : cnt_q + 7'h01;
      clear_o <= (cnt_q == 7'h63);
    end
  end

  always_ff @(posedge clock_i) begin
    sleep_o <= rst_n_i & sleep_req_i;
  end
endmodule : wdt_core_model

// File: sim/testbench.sv
// Self-checking bench for the watchdog core and its core model.
// Assumes a 100 MHz clock; the model makes the slow clocks.
`timescale 1ns/1ps
module testbench
  import wdt_pkg::*;
();
  logic              clk      = 1'b0;
  logic              rst_n    = 1'b0;
  logic [ADDR_W-1:0] addr     = 12'h000;
  logic [DATA_W-1:0] wdata    = 8'h00;
  logic              wr       = 1'b0;
  logic              rd       = 1'b0;
  logic [1:0]        mode     = 2'h0;
  logic              global_interrupt_enable      = 1'b0;
  logic              pend     = 1'b0;
  logic              auto_clr = 1'b0;
  logic              slp_req  = 1'b0;
  logic [DATA_W-1:0] rdata;
  logic              clr, slp, secondary_oscillator, lfosc, wrst, wake, isr, asleep;
  logic              to_n, pd_n, rw_n, irq;
  int                errors   = 0;
  int                n_tests  = 0;
  int                cycles   = 0;

  wdt_core_model wdt_core_model_i (.clock_i(clk), .rst_n_i(rst_n),
    .auto_clear_i(auto_clr), .sleep_req_i(slp_req), .clear_o(clr),
    .sleep_o(slp), .secondary_oscillator_o(secondary_oscillator), .lfosc_o(lfosc));

  wdt_core wdt_core_i (.clock_i(clk), .rst_n_i(rst_n), .addr_i(addr),
    .wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata),
    .wdt_mode_select_i(mode), .watchdog_clear_instruction_i(clr),
    .sleep_instruction_i(slp), .global_interrupt_enable_i(global_interrupt_enable),
    .interrupt_pending_i(pend), .secondary_oscillator_i(secondary_oscillator),
    .low_freq_internal_osc_i(lfosc), .wdt_reset_o(wrst), .wake_o(wake),
    .isr_call_o(isr), .asleep_o(asleep), .time_out_flag_n_o(to_n),
    .powerdown_flag_n_o(pd_n), .watchdog_reset_flag_n_o(rw_n),
    .irq_o(irq));

  initial begin
    forever #5 clk = ~clk;
  end

  // A hang counts as a mismatch rather than running forever.
  always @(posedge clk) begin
    cycles++;
    if (cycles == 40000) begin
      errors++;
      complete_run();
    end
  end

  // ------------------------------------------------------------
  // Shared tasks
  // ------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] exp,
                     input logic [31:0] got);
    n_tests++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk

  task automatic do_reset;
    @(posedge clk);
    rst_n <= 1'b0;
    repeat (8) @(posedge clk);
    rst_n <= 1'b1;
  endtask : do_reset

  task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr    <= 1'b1;
    @(posedge clk);
    wr    <= 1'b0;
  endtask : wr_reg

  task automatic rd_chk(input logic [11:0] a, input logic [7:0] e,
                        input string nm);
    @(posedge clk);
    addr <= a;
    rd   <= 1'b1;
    @(posedge clk);
    rd   <= 1'b0;
    #1;
    chk(nm, {24'h0, e}, {24'h0, rdata});
  endtask : rd_chk

  task automatic wait_for(input int sel, input int lim, output int n);
    n = 0;
    while (n < lim && (sel ? wake : wrst) !== 1'b1) begin
      @(posedge clk);
      #1;
      n++;
    end
  endtask : wait_for

  task automatic sleep_now;
    @(posedge clk);
    slp_req <= 1'b1;
    @(posedge clk);
    slp_req <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
  endtask : sleep_now

  task automatic start(input logic [1:0] m, input logic [7:0] c);
    do_reset();
    @(posedge clk);
    mode <= m;
    wr_reg(ADDR_CONTROL, c);
  endtask : start

  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    do_reset();
    rd_chk(ADDR_CONTROL, 8'h16, "ctl reset");
    rd_chk(ADDR_FLAGS, 8'h07, "flags reset");
    wr_reg(ADDR_CONTROL, 8'hFF);
    rd_chk(ADDR_CONTROL, 8'hBF, "ctl bit6");
    rd_chk(12'h1A0, 8'h00, "unmapped");
  endtask : t_regs

  task automatic t_modes;
    logic [1:0] m [8] = '{2'h0, 2'h1, 2'h1, 2'h2, 2'h3, 2'h3, 2'h3, 2'h3};
    logic [7:0] c [8] = '{8'h01, 8'h00, 8'h01, 8'h00, 8'h00, 8'h27, 8'h80,
                          8'h02};
    int n, ps, ex;
    for (int i = 0; i < 8; i++) begin
      start(m[i], c[i]);
      ps = (c[i][5:1] > 5'h12) ? 0 : int'(c[i][5:1]);
      ex = (32 << ps) * (c[i][7] ? 16 : 8);
      wait_for(0, 1200, n);
      if (m[i] == 2'h0 || (m[i] == 2'h1 && !c[i][0])) begin
        chk("no expiry", 32'h1, n == 1200);
      end else begin
        chk("expiry time", 32'h1, n > ex - 16 && n < ex + 16);
      end
    end
  endtask : t_modes

  task automatic t_clear;
    int n;
    start(MODE_ALWAYS, 8'h00);
    auto_clr <= 1'b1;
    wait_for(0, 800, n);
    chk("cleared in time", 32'h1, n == 800);
    @(posedge clk);
    auto_clr <= 1'b0;
    wr_reg(ADDR_CONTROL, 8'h00);
    repeat (200) @(posedge clk);
    wr_reg(ADDR_CONTROL, 8'h00);
    wait_for(0, 400, n);
    chk("write restarts", 32'h1, n > 240 && n < 272);
    chk("to flag", 32'h0, to_n);
  endtask : t_clear

  task automatic t_sleep_to;
    int n;
    start(MODE_ALWAYS, 8'h00);
    repeat (150) @(posedge clk);
    sleep_now();
    chk("sleep entry", 32'h2, {asleep, pd_n});
    wait_for(1, 400, n);
    chk("wake time", 32'h1, n > 240 && n < 272);
    chk("wake flags", 32'h0, {to_n, pd_n, rw_n, asleep, wrst});
  endtask : t_sleep_to

  task automatic t_sleep_int;
    int n;
    start(MODE_AWAKE, 8'h00);
    pend <= 1'b1;
    sleep_now();
    chk("nop sleep", 32'h1, {asleep, pd_n});
    for (int g = 0; g < 2; g++) begin
      @(posedge clk);
      pend <= 1'b0;
      global_interrupt_enable  <= g[0];
      sleep_now();
      wait_for(1, 700, n);
      chk("no wake", 32'h1, n == 700);
      @(posedge clk);
      pend <= 1'b1;
      wait_for(1, 10, n);
      chk("isr call", g, isr);
      chk("int wake", 32'h2, {asleep, to_n, pd_n});
    end
  endtask : t_sleep_int

  task automatic t_irq;
    int n;
    start(MODE_ALWAYS, 8'h00);
    wait_for(0, 400, n);
    rd_chk(ADDR_IRQ_STAT, 8'h01, "irq status");
    rd_chk(ADDR_FLAGS, 8'h02, "flags after expiry");
    chk("irq masked", 32'h0, irq);
    wr_reg(ADDR_IRQ_MASK, 8'h01);
    #1;
    chk("irq on", 32'h1, irq);
    wr_reg(ADDR_IRQ_STAT, 8'h01);
    #1;
    chk("irq cleared", 32'h0, irq);
    wr_reg(ADDR_FLAGS, 8'h07);
    rd_chk(ADDR_FLAGS, 8'h07, "flags restored");
  endtask : t_irq

  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", n_tests, errors);
    if (errors == 0 && n_tests > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : complete_run

  initial begin
    t_regs();
    t_modes();
    t_clear();
    t_sleep_to();
    t_sleep_int();
    t_irq();
    complete_run();
  end
endmodule : testbench

bind wdt_core wdt_checker wdt_checker_i (.*);
